/* design/alupc_core.sv */
// alu datapath, flags and program counter flow with avalon register access
`timescale 1ns/1ps
`default_nettype none
module alupc_core (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_op_valid,
   input wire alupc_pkg::alupc_op_e i_op,
   input wire logic [alupc_pkg::DW-1:0] i_dst_val,
   input wire logic [alupc_pkg::DW-1:0] i_src_val,
   input wire logic [alupc_pkg::DW-1:0] i_hi_val,
   input wire logic [alupc_pkg::DW-1:0] i_imm,
   input wire logic [alupc_pkg::OFFW-1:0] i_rel_offset,
   input wire logic [alupc_pkg::PCW-1:0] i_z_ptr,
   output logic o_busy,
   output logic o_done,
   output logic o_wr_en,
   output logic o_wr_hi_en,
   output logic [alupc_pkg::DW-1:0] o_wr_data,
   output logic [alupc_pkg::DW-1:0] o_wr_hi_data,
   output logic [alupc_pkg::DW-1:0] o_flags,
   output logic [alupc_pkg::PCW-1:0] o_pc,
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest
);
   import alupc_pkg::*;

   alupc_state_e state;
   logic [CNTW-1:0] cnt;
   logic [SPW-1:0] sp;
   alupc_op_e cur_op;
   logic [7:0] pend_flags;
   logic [15:0] pend_pc;
   logic [15:0] pend_ret;
   logic pend_wr;
   logic pend_wr_hi;
   logic [7:0] ret_hi;
   logic [7:0] ret_lo;
   logic [7:0] rd_data;
   logic av_ack;

   logic [10:0] ar;
   logic c_arith;
   logic c_word;
   logic [7:0] c_res;
   logic [7:0] c_hi;
   logic c_c;
   logic c_v;
   logic c_h;
   logic [7:0] c_mask;
   logic c_wr;
   logic c_wr_hi;
   logic [CNTW-1:0] c_cyc;
   logic [15:0] c_target;

   ////////////////////////////////////////////////////////////////////////
   // handshake and sequencing terms
   wire logic av_req = i_avs_read | i_avs_write;
   wire logic av_wr_go = av_ack & i_avs_write;
   wire logic is_busy = (state == ST_BUSY);
   assign o_busy = is_busy | av_wr_go;
   wire logic take = i_op_valid & ~o_busy;
   wire logic finish = is_busy & (cnt == CYC_ONE);
   wire logic one_cyc = (c_cyc == CYC_ONE);
   wire logic take_call = take & ((i_op == OP_REL_SUB_CALL) |
                                  (i_op == OP_PTR_SUB_CALL));
   wire logic cur_call = (cur_op == OP_REL_SUB_CALL) |
                         (cur_op == OP_PTR_SUB_CALL);
   wire logic cur_ret = (cur_op == OP_SUB_EXIT) | (cur_op == OP_IRQ_EXIT);
   wire logic carry_in = o_flags[FL_C];

   ////////////////////////////////////////////////////////////////////////
   // word arithmetic on the register pair
   wire logic [15:0] pair = {i_hi_val, i_dst_val};
   wire logic [16:0] w_add = {1'b0, pair} + {9'h000, i_imm};
   wire logic [16:0] w_sub = {1'b0, pair} - {9'h000, i_imm};
   wire logic [16:0] w_res = (i_op == OP_WORD_IMM_MINUS) ? w_sub : w_add;
   // add overflows when positive turns negative, subtract the reverse
   wire logic w_v = (i_op == OP_WORD_IMM_MINUS) ?
                    (pair[15] & ~w_sub[15]) : (~pair[15] & w_add[15]);

   // program counter targets
   wire logic [15:0] rel_ext = {{(PCW-OFFW){i_rel_offset[OFFW-1]}},
                                i_rel_offset};
   wire logic [15:0] pc_next = o_pc + PC_STEP;
   wire logic [15:0] rel_target = o_pc + rel_ext + PC_STEP;

   ////////////////////////////////////////////////////////////////////////
   // operation decode: value, raw flag terms and which flags change
   always_comb begin
      ar = 11'h000;
      c_arith = 1'b0;
      c_word = 1'b0;
      c_res = i_dst_val;
      c_hi = i_hi_val;
      c_c = o_flags[FL_C];
      c_v = 1'b0;
      c_h = o_flags[FL_H];
      c_mask = MSK_ZNV;
      c_wr = 1'b1;
      c_wr_hi = 1'b0;
      c_cyc = CYC_ONE;
      c_target = pc_next;
      unique case (i_op)
         OP_SUM_TWO_REGS: begin
            ar = alupc_add8(i_dst_val, i_src_val, 1'b0);
            c_arith = 1'b1;
         end
         OP_SUM_WITH_CARRY: begin
            ar = alupc_add8(i_dst_val, i_src_val, carry_in);
            c_arith = 1'b1;
         end
         OP_WORD_IMM_SUM, OP_WORD_IMM_MINUS: begin
            c_word = 1'b1;
            c_res = w_res[7:0];
            c_hi = w_res[15:8];
            c_c = w_res[16];
            c_v = w_v;
            c_mask = MSK_ZCNVS;
            c_wr_hi = 1'b1;
            c_cyc = CYC_WORD;
         end
         OP_MINUS_REG: begin
            ar = alupc_sub8(i_dst_val, i_src_val, 1'b0);
            c_arith = 1'b1;
         end
         OP_MINUS_REG_BORROW: begin
            ar = alupc_sub8(i_dst_val, i_src_val, carry_in);
            c_arith = 1'b1;
         end
         OP_MINUS_CONST: begin
            ar = alupc_sub8(i_dst_val, i_imm, 1'b0);
            c_arith = 1'b1;
         end
         OP_MINUS_CONST_BORROW: begin
            ar = alupc_sub8(i_dst_val, i_imm, carry_in);
            c_arith = 1'b1;
         end
         OP_MASK_REGS: c_res = i_dst_val & i_src_val;
         OP_MASK_CONST: c_res = i_dst_val & i_imm;
         OP_MERGE_REGS: c_res = i_dst_val | i_src_val;
         OP_MERGE_CONST: c_res = i_dst_val | i_imm;
         OP_XOR_REGS: c_res = i_dst_val ^ i_src_val;
         OP_SET_MASK_BITS: c_res = i_dst_val | i_imm;
         OP_CLEAR_MASK_BITS: c_res = i_dst_val & (ALL_ONES - i_imm);
         OP_INVERT_REG: begin
            c_res = ALL_ONES - i_dst_val;
            c_c = 1'b1;
            c_mask = MSK_ZCNV;
         end
         OP_TWOS_FLIP_REG: begin
            ar = alupc_sub8(ZERO8, i_dst_val, 1'b0);
            c_arith = 1'b1;
         end
         OP_PLUS_ONE: begin
            ar = alupc_add8(i_dst_val, ONE8, 1'b0);
            c_res = ar[7:0];
            c_v = ar[8];
         end
         OP_MINUS_ONE: begin
            ar = alupc_sub8(i_dst_val, ONE8, 1'b0);
            c_res = ar[7:0];
            c_v = ar[8];
         end
         OP_PROBE_REG: c_res = i_dst_val & i_dst_val;
         OP_ZERO_REG: c_res = i_dst_val ^ i_dst_val;
         OP_ALL_ONES_REG: begin
            c_res = ALL_ONES;
            c_mask = MSK_NONE;
         end
         OP_REL_JUMP, OP_REL_SUB_CALL: begin
            c_target = rel_target;
            c_mask = MSK_NONE;
            c_wr = 1'b0;
            c_cyc = (i_op == OP_REL_JUMP) ? CYC_JUMP : CYC_CALL;
         end
         OP_PTR_JUMP, OP_PTR_SUB_CALL: begin
            c_target = i_z_ptr;
            c_mask = MSK_NONE;
            c_wr = 1'b0;
            c_cyc = (i_op == OP_PTR_JUMP) ? CYC_JUMP : CYC_CALL;
         end
         OP_SUB_EXIT: begin
            c_mask = MSK_NONE;
            c_wr = 1'b0;
            c_cyc = CYC_RET;
         end
         OP_IRQ_EXIT: begin
            c_mask = MSK_IEN;
            c_wr = 1'b0;
            c_cyc = CYC_RET;
         end
         default: begin
            // unassigned codes only step the pc
            c_mask = MSK_NONE;
            c_wr = 1'b0;
         end
      endcase
      if (c_arith) begin
         c_res = ar[7:0];
         c_c = ar[9];
         c_v = ar[8];
         c_h = ar[10];
         c_mask = MSK_ZCNVH;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flag candidates, merged under the mask
   wire logic f_z = c_word ? ({c_hi, c_res} == 16'h0000) :
                             (c_res == ZERO8);
   wire logic f_n = c_word ? c_hi[7] : c_res[7];
   wire logic [7:0] f_cand = {1'b1, o_flags[6], c_h, f_n ^ c_v, c_v,
                              f_n, f_z, c_c};
   wire logic [7:0] next_flags = (o_flags & ~c_mask) | (f_cand & c_mask);

   // stack port: push low then high, pop high then low
   wire logic st_we = take_call | (is_busy & cur_call & (cnt == CYC_WORD));
   wire logic [SPW-1:0] st_waddr = is_busy ? (sp - SP_ONE) : sp;
   wire logic [7:0] st_wdata = is_busy ? pend_ret[15:8] : pc_next[7:0];
   wire logic [SPW-1:0] st_raddr = is_busy ? (sp + SP_TWO) : (sp + SP_ONE);

   alupc_stack_ram u_stack (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_wr_en(st_we),
      .i_wr_addr(st_waddr),
      .i_wr_data(st_wdata),
      .i_rd_addr(st_raddr),
      .o_rd_data(rd_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // sequencer: multi-cycle ops count down to their finish edge
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state <= ST_IDLE;
         cnt <= CYC_ONE;
      end else if (take && !one_cyc) begin
         state <= ST_BUSY;
         cnt <= c_cyc - CYC_ONE;
      end else if (finish) begin
         state <= ST_IDLE;
      end else if (is_busy) begin
         cnt <= cnt - CYC_ONE;
      end
   end

   // operation context held while busy
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cur_op <= OP_SUM_TWO_REGS;
         pend_flags <= FLAGS_RST;
         pend_pc <= PC_RST;
         pend_ret <= PC_RST;
         pend_wr <= 1'b0;
         pend_wr_hi <= 1'b0;
      end else if (take) begin
         cur_op <= i_op;
         pend_flags <= next_flags;
         pend_pc <= c_target;
         pend_ret <= pc_next;
         pend_wr <= c_wr;
         pend_wr_hi <= c_wr_hi;
      end
   end

   // popped return address bytes
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ret_hi <= ZERO8;
         ret_lo <= ZERO8;
      end else if (is_busy && cur_ret) begin
         if (cnt == CYC_CALL) ret_hi <= rd_data;
         if (cnt == CYC_WORD) ret_lo <= rd_data;
      end
   end

   // result data is presented at take; the strobes mark completion
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_wr_data <= ZERO8;
         o_wr_hi_data <= ZERO8;
         o_wr_en <= 1'b0;
         o_wr_hi_en <= 1'b0;
         o_done <= 1'b0;
      end else begin
         if (take) o_wr_data <= c_res;
         if (take) o_wr_hi_data <= c_hi;
         o_wr_en <= (take & one_cyc & c_wr) | (finish & pend_wr);
         o_wr_hi_en <= finish & pend_wr_hi;
         o_done <= (take & one_cyc) | finish;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // architectural state: bus writes only land while idle
   wire logic wr_flags = av_wr_go & (i_avs_address[3:2] == REG_FLAGS);
   wire logic wr_pc = av_wr_go & (i_avs_address[3:2] == REG_PC);
   wire logic wr_sp = av_wr_go & (i_avs_address[3:2] == REG_SP);

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_flags <= FLAGS_RST;
      end else if (wr_flags && i_avs_byteenable[0]) begin
         o_flags <= i_avs_writedata[7:0];
      end else if (take && one_cyc) begin
         o_flags <= next_flags;
      end else if (finish) begin
         o_flags <= pend_flags;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_pc <= PC_RST;
      end else if (wr_pc) begin
         if (i_avs_byteenable[0]) o_pc[7:0] <= i_avs_writedata[7:0];
         if (i_avs_byteenable[1]) o_pc[15:8] <= i_avs_writedata[15:8];
      end else if (take && one_cyc) begin
         o_pc <= c_target;
      end else if (finish) begin
         o_pc <= cur_ret ? {ret_hi, ret_lo} : pend_pc;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sp <= SP_RST;
      end else if (wr_sp && i_avs_byteenable[0]) begin
         sp <= i_avs_writedata[SPW-1:0];
      end else if (finish && cur_call) begin
         sp <= sp - SP_TWO;
      end else if (finish && cur_ret) begin
         sp <= sp + SP_TWO;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // avalon slave: one wait state, and none accepted while an op runs
   assign o_avs_waitrequest = av_req & ~av_ack;
   wire logic av_ack_go = av_req & ~av_ack & ~is_busy & ~i_op_valid;
   wire logic [31:0] rd_mux =
      (i_avs_address[3:2] == REG_FLAGS) ? {24'h000000, o_flags} :
      (i_avs_address[3:2] == REG_PC) ? {16'h0000, o_pc} :
      (i_avs_address[3:2] == REG_SP) ? {25'h0000000, sp} :
      {31'h00000000, is_busy};

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         av_ack <= 1'b0;
         o_avs_readdata <= 32'h00000000;
      end else begin
         av_ack <= av_ack_go;
         if (av_ack_go && i_avs_read) o_avs_readdata <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);

   sequence busy_one_s;
      o_busy ##1 (!o_busy && o_done);
   endsequence
   sequence busy_two_s;
      o_busy [*2] ##1 (!o_busy && o_done);
   endsequence
   sequence busy_three_s;
      o_busy [*3] ##1 (!o_busy && o_done);
   endsequence

   sum_result_a: assert property (
      take && i_op == OP_SUM_WITH_CARRY |=> o_wr_en && o_wr_data ==
      8'($past(i_dst_val) + $past(i_src_val) + {7'h00, $past(carry_in)}))
      else $error("sum with carry result wrong");
   word_sum_a: assert property (
      take && i_op == OP_WORD_IMM_SUM |=> busy_one_s ##0
      o_wr_hi_en && {o_wr_hi_data, o_wr_data} == $past(w_add[15:0], 2))
      else $error("word add result or timing wrong");
   word_minus_a: assert property (
      take && i_op == OP_WORD_IMM_MINUS |-> ##2 o_flags[FL_C] ==
      $past(w_sub[16], 2) && o_flags[FL_S] == (o_flags[FL_N] ^ o_flags[FL_V]))
      else $error("word subtract flags wrong");
   minus_borrow_a: assert property (
      take && i_op == OP_MINUS_REG |=>
      o_flags[FL_C] == ($past(i_src_val) > $past(i_dst_val)))
      else $error("subtract borrow flag wrong");
   mask_flags_a: assert property (
      take && i_op == OP_MASK_CONST |=> !o_flags[FL_V] &&
      $stable(o_flags[FL_C]) && $stable(o_flags[FL_H]))
      else $error("and touched wrong flags");
   clear_bits_a: assert property (
      take && i_op == OP_CLEAR_MASK_BITS |=>
      o_wr_data == ($past(i_dst_val) & ~$past(i_imm)) &&
      o_flags[FL_Z] == (o_wr_data == ZERO8))
      else $error("clear bits result wrong");
   ones_keep_a: assert property (
      take && i_op == OP_ALL_ONES_REG |=>
      $stable(o_flags) && o_wr_data == ALL_ONES && !o_busy)
      else $error("set register changed flags");
   rel_jump_a: assert property (
      take && i_op == OP_REL_JUMP |=> busy_one_s ##0
      o_pc == $past(rel_target, 2) && !o_wr_en)
      else $error("relative jump target or timing wrong");
   call_push_a: assert property (
      take_call |=> busy_two_s ##0 sp == $past(sp, 3) - SP_TWO)
      else $error("call did not push two bytes in three cycles");
   exit_pop_a: assert property (
      take && i_op == OP_IRQ_EXIT |=> busy_three_s ##0
      o_flags[FL_I] && sp == $past(sp, 4) + SP_TWO)
      else $error("interrupt return timing or enable wrong");
endmodule
`default_nettype wire

/* design/alupc_pkg.sv */
// constants, types and arithmetic helpers of the alu and pc flow unit
//
// Notes on behaviour
// - sum_two_regs adds src_reg into dest_reg; sum_with_carry adds carry too.
// - word_imm_sum adds imm_const to the register pair in two cycles.
// - word_imm_minus subtracts imm_const from the register pair, two cycles.
// - minus_reg subtracts src_reg; minus_reg_borrow also subtracts carry.
// - minus_const subtracts imm_const; minus_const_borrow also subtracts carry.
// - mask_regs and mask_const AND into dest_reg; only zero, negative, overflow.
// - merge ops OR, xor_regs XORs into dest_reg; zero, negative, overflow.
// - set_mask_bits ORs the mask into dest_reg in one cycle.
// - clear_mask_bits ANDs dest_reg with FF minus the mask.
// - single-operand ops take one cycle; all_ones_reg leaves flags alone.
// - rel_jump goes to pc plus offset plus one, ptr_jump to Z; two cycles.
// - calls take three cycles, sub_exit and irq_exit four, popping pc.
package alupc_pkg;
   localparam int DW = 8;
   localparam int PCW = 16;
   localparam int OFFW = 12;
   localparam int SPW = 7;
   localparam int CNTW = 3;
   // status flag bit positions
   localparam int FL_C = 0;
   localparam int FL_Z = 1;
   localparam int FL_N = 2;
   localparam int FL_V = 3;
   localparam int FL_S = 4;
   localparam int FL_H = 5;
   localparam int FL_I = 7;
   // flag update masks per operation class
   localparam logic [7:0] MSK_ZCNVH = 8'h2F;
   localparam logic [7:0] MSK_ZCNVS = 8'h1F;
   localparam logic [7:0] MSK_ZCNV = 8'h0F;
   localparam logic [7:0] MSK_ZNV = 8'h0E;
   localparam logic [7:0] MSK_NONE = 8'h00;
   localparam logic [7:0] MSK_IEN = 8'h80;
   localparam logic [7:0] ALL_ONES = 8'hFF;
   localparam logic [7:0] ZERO8 = 8'h00;
   localparam logic [7:0] ONE8 = 8'h01;
   // reset values and step constants
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [15:0] PC_RST = 16'h0000;
   localparam logic [15:0] PC_STEP = 16'h0001;
   localparam logic [6:0] SP_RST = 7'h7F;
   localparam logic [6:0] SP_ONE = 7'h01;
   localparam logic [6:0] SP_TWO = 7'h02;
   // cycle counts
   localparam logic [2:0] CYC_ONE = 3'h1;
   localparam logic [2:0] CYC_WORD = 3'h2;
   localparam logic [2:0] CYC_JUMP = 3'h2;
   localparam logic [2:0] CYC_CALL = 3'h3;
   localparam logic [2:0] CYC_RET = 3'h4;
   // avalon register indices on address bits 3:2, then byte offsets
   localparam logic [1:0] REG_FLAGS = 2'h0;
   localparam logic [1:0] REG_PC = 2'h1;
   localparam logic [1:0] REG_SP = 2'h2;
   localparam logic [1:0] REG_STAT = 2'h3;
   localparam logic [3:0] OFS_FLAGS = 4'h0;
   localparam logic [3:0] OFS_PC = 4'h4;
   localparam logic [3:0] OFS_SP = 4'h8;
   localparam logic [3:0] OFS_STAT = 4'hC;
   localparam int STAT_BUSY = 0;

   typedef enum logic [4:0] {
      OP_SUM_TWO_REGS = 5'h00, OP_SUM_WITH_CARRY = 5'h01,
      OP_WORD_IMM_SUM = 5'h02, OP_MINUS_REG = 5'h03,
      OP_MINUS_CONST = 5'h04, OP_WORD_IMM_MINUS = 5'h05,
      OP_MINUS_REG_BORROW = 5'h06, OP_MINUS_CONST_BORROW = 5'h07,
      OP_MASK_REGS = 5'h08, OP_MASK_CONST = 5'h09,
      OP_MERGE_REGS = 5'h0A, OP_MERGE_CONST = 5'h0B,
      OP_XOR_REGS = 5'h0C, OP_INVERT_REG = 5'h0D,
      OP_TWOS_FLIP_REG = 5'h0E, OP_SET_MASK_BITS = 5'h0F,
      OP_CLEAR_MASK_BITS = 5'h10, OP_PLUS_ONE = 5'h11,
      OP_MINUS_ONE = 5'h12, OP_PROBE_REG = 5'h13,
      OP_ZERO_REG = 5'h14, OP_ALL_ONES_REG = 5'h15,
      OP_REL_JUMP = 5'h16, OP_PTR_JUMP = 5'h17,
      OP_REL_SUB_CALL = 5'h18, OP_PTR_SUB_CALL = 5'h19,
      OP_SUB_EXIT = 5'h1A, OP_IRQ_EXIT = 5'h1B
   } alupc_op_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_BUSY = 2'b10
   } alupc_state_e;

   // result packed as {half, carry, overflow, value}
   function automatic logic [10:0] alupc_add8(input logic [7:0] a,
         input logic [7:0] b, input logic cin);
      logic [8:0] s;
      logic [4:0] l;
      s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      l = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      return {l[4], s[8], (a[7] == b[7]) && (s[7] != a[7]), s[7:0]};
   endfunction

   // carry and half here mean borrow out of bit 7 and bit 3
   function automatic logic [10:0] alupc_sub8(input logic [7:0] a,
         input logic [7:0] b, input logic cin);
      logic [8:0] s;
      logic [4:0] l;
      s = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      l = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
      return {l[4], s[8], (a[7] != b[7]) && (s[7] != a[7]), s[7:0]};
   endfunction
endpackage

/* design/alupc_stack_ram.sv */
// return-address stack memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module alupc_stack_ram (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_wr_en,
   input wire logic [alupc_pkg::SPW-1:0] i_wr_addr,
   input wire logic [alupc_pkg::DW-1:0] i_wr_data,
   input wire logic [alupc_pkg::SPW-1:0] i_rd_addr,
   output logic [alupc_pkg::DW-1:0] o_rd_data
);
   import alupc_pkg::*;

   logic [DW-1:0] mem [0:(1<<SPW)-1];

   // array carries no reset, contents are undefined until pushed
   always_ff @(posedge i_core_clk) begin
      if (i_wr_en) begin
         mem[i_wr_addr] <= i_wr_data;
      end
   end

   // one-cycle read latency
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rd_data <= ZERO8;
      end else begin
         o_rd_data <= mem[i_rd_addr];
      end
   end
endmodule
`default_nettype wire

/* verif/alupc_regfile_model.sv */
// register file stand-in holding the dest pair
`timescale 1ns/1ps
`default_nettype none
module alupc_regfile_model (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_load,
   input wire logic [15:0] i_load_val,
   input wire logic i_wr_en,
   input wire logic i_wr_hi_en,
   input wire logic [7:0] i_wr_data,
   input wire logic [7:0] i_wr_hi_data,
   output logic [15:0] o_pair
);
   // bench load wins; write-back lands one edge after done
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_pair <= 16'h0000;
      end else if (i_load) begin
         o_pair <= i_load_val;
      end else begin
         if (i_wr_en) o_pair[7:0] <= i_wr_data;
         if (i_wr_hi_en) o_pair[15:8] <= i_wr_hi_data;
      end
   end
endmodule
`default_nettype wire

/* verif/alu_and_pc_flow_unit_tb_top.sv */
// self-checking bench of the alu and pc flow unit
`timescale 1ns/1ps
`default_nettype none
module alu_and_pc_flow_unit_tb_top;
   import alupc_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic vld = 1'b0, ld = 1'b0, rd = 1'b0, wr = 1'b0, c, busy, done, we, whe;
   alupc_op_e op = OP_SUM_TWO_REGS, opc;
   logic [7:0] src = 8'h00, imm = 8'h00, wdat, whdat, fl;
   logic [11:0] off = 12'h000;
   logic [15:0] zp = 16'h0000, ldv = 16'h0000, pair, pc, p, t;
   logic [3:0] adr = 4'h0;
   logic [31:0] wd = 32'h0, rdq, q, seed = 32'hACE4;
   logic [23:0] e;
   logic wreq;
   int err_count = 0, samples_checked = 0, cyc = 0;
   alupc_core i_alupc_core (.i_core_clk(clk), .i_nrst(nrst), .i_op_valid(vld),
      .i_op(op), .i_dst_val(pair[7:0]), .i_src_val(src), .i_hi_val(pair[15:8]),
      .i_imm(imm), .i_rel_offset(off), .i_z_ptr(zp), .o_busy(busy),
      .o_done(done), .o_wr_en(we), .o_wr_hi_en(whe), .o_wr_data(wdat),
      .o_wr_hi_data(whdat), .o_flags(fl), .o_pc(pc), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
      .i_avs_byteenable(4'hF), .o_avs_readdata(rdq),
      .o_avs_waitrequest(wreq));
   alupc_regfile_model i_alupc_regfile_model (.i_core_clk(clk), .i_nrst(nrst),
      .i_load(ld), .i_load_val(ldv), .i_wr_en(we), .i_wr_hi_en(whe),
      .i_wr_data(wdat), .i_wr_hi_data(whdat), .o_pair(pair));
   always #4 clk = ~clk;
   // hang guard, far above the few hundred cycles needed
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         report_and_stop();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // request held until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      adr <= a;
      wr <= w;
      rd <= !w;
      wd <= d;
      do @(posedge clk); while (wreq !== 1'b0);
      q = rdq;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask
   // load operands, take op, count edges until done is seen
   task automatic run(input alupc_op_e o, input logic [15:0] v, input int n);
      int k;
      ldv <= v;
      ld <= 1'b1;
      @(posedge clk);
      ld <= 1'b0;
      op <= o;
      vld <= 1'b1;
      @(posedge clk);
      vld <= 1'b0;
      k = 0;
      do begin @(posedge clk); k++; end while (done !== 1'b1);
      chk("cycles", k, n);
      @(posedge clk);
   endtask
   // reference: {flags, pair}; flags start as written over the bus
   function automatic logic [23:0] ref_op(input alupc_op_e o,
         input logic [15:0] p, input logic [7:0] s, k, input logic c);
      logic [7:0] d, b, r;
      logic [16:0] w;
      logic [4:0] l;
      logic sb, v, ci;
      d = p[7:0];
      b = (o inside {OP_MINUS_CONST, OP_MINUS_CONST_BORROW}) ? k : s;
      ci = c & (o inside {OP_SUM_WITH_CARRY, OP_MINUS_REG_BORROW,
         OP_MINUS_CONST_BORROW});
      sb = !(o inside {OP_SUM_TWO_REGS, OP_SUM_WITH_CARRY});
      if (o == OP_TWOS_FLIP_REG) begin
         b = d;
         d = 8'h00;
      end
      if (o inside {OP_WORD_IMM_SUM, OP_WORD_IMM_MINUS}) begin
         w = (o == OP_WORD_IMM_SUM) ? {1'b0, p} + k : {1'b0, p} - k;
         // add overflows from plus to minus, subtract from minus to plus
         v = (p[15] == (o == OP_WORD_IMM_MINUS)) && (w[15] != p[15]);
         return {3'h0, w[15] ^ v, v, w[15], w[15:0] == 0, w[16], w[15:0]};
      end
      if (o inside {OP_SUM_TWO_REGS, OP_SUM_WITH_CARRY, OP_MINUS_REG,
            OP_MINUS_CONST, OP_MINUS_REG_BORROW, OP_MINUS_CONST_BORROW,
            OP_TWOS_FLIP_REG}) begin
         w = sb ? {9'h0, d} - b - ci : {9'h0, d} + b + ci;
         l = sb ? {1'b0, d[3:0]} - b[3:0] - ci : {1'b0, d[3:0]} + b[3:0] + ci;
         v = ((d[7] ^ b[7]) == sb) && (w[7] != d[7]);
         return {2'h0, l[4], 1'b0, v, w[7], w[7:0] == 0, w[8], p[15:8], w[7:0]};
      end
      case (o)
         OP_MASK_REGS: r = d & s;
         OP_MASK_CONST: r = d & k;
         OP_MERGE_REGS: r = d | s;
         OP_XOR_REGS: r = d ^ s;
         OP_CLEAR_MASK_BITS: r = d & (8'hFF - k);
         OP_INVERT_REG: r = 8'hFF - d;
         OP_PLUS_ONE: r = d + 8'h01;
         OP_MINUS_ONE: r = d - 8'h01;
         OP_PROBE_REG: r = d & d;
         OP_ZERO_REG: r = d ^ d;
         OP_ALL_ONES_REG: return {7'h00, c, p[15:8], 8'hFF};
         default: r = d | k;
      endcase
      v = (o == OP_PLUS_ONE && d == 8'h7F) || (o == OP_MINUS_ONE && d == 8'h80);
      return {4'h0, v, r[7], r == 0, c | (o == OP_INVERT_REG), p[15:8], r};
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      bus(1'b0, OFS_SP, 32'h0);
      chk("sp", q, 32'h7F);
      // every alu code; last third pins dest to the overflow edges
      for (int i = 0; i < 66; i++) begin
         seed = lfsr(seed);
         p = seed[15:0];
         if (i >= 44) p[7:0] = i[1] ? 8'h7F : 8'h80;
         c = seed[20];
         opc = alupc_op_e'(i % 22);
         src <= seed[23:16];
         imm <= seed[31:24];
         e = ref_op(opc, p, seed[23:16], seed[31:24], c);
         bus(1'b1, OFS_FLAGS, {31'h0, c});
         run(opc, p, (opc inside {OP_WORD_IMM_SUM, OP_WORD_IMM_MINUS}) ? 2 : 1);
         chk("result", pair, e[15:0]);
         chk("low", pair[7:0], e[7:0]);
         chk("flags", fl, e[23:16]);
      end
      $display("test alu done");
      seed = lfsr(seed);
      t = seed[31:16];
      off <= seed[11:0];
      zp <= {seed[7:0], seed[15:8]};
      bus(1'b1, OFS_PC, {16'h0, t});
      run(OP_REL_JUMP, 16'h0000, 2);
      t = t + {{4{seed[11]}}, seed[11:0]} + 16'h0001;
      chk("pc", pc, t);
      chk("flags", fl, e[23:16]);
      run(OP_PTR_SUB_CALL, 16'h0000, 3);
      chk("pc", pc, zp);
      run(OP_REL_SUB_CALL, 16'h0000, 3);
      chk("pc", pc, 16'(zp + {{4{off[11]}}, off} + 16'h0001));
      bus(1'b0, OFS_SP, 32'h0);
      chk("sp", q, 32'h7B);
      run(OP_SUB_EXIT, 16'h0000, 4);
      chk("pc", pc, 16'(zp + 16'h0001));
      run(OP_IRQ_EXIT, 16'h0000, 4);
      chk("pc", pc, 16'(t + 16'h0001));
      chk("flags", fl, e[23:16] | 8'h80);
      run(OP_PTR_JUMP, 16'h0000, 2);
      chk("pc", pc, zp);
      bus(1'b0, OFS_SP, 32'h0);
      chk("sp", q, 32'h7F);
      $display("test flow done");
      report_and_stop();
   end
endmodule
`default_nettype wire
